// [hdl/ahs_homing.sv]
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
module ahs_homing (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic neg_limit_i,
  input wire logic pos_limit_i,
  input wire logic home_sw_i,
  input wire logic index_i,
  input wire logic [15:0] motor_current_i,
  input wire logic standstill_i,
  input wire logic [31:0] pos_delta_i,
  input wire logic pos_step_i,
  output logic [31:0] speed_cmd_o,
  output logic [31:0] accel_cmd_o,
  output logic dir_neg_o,
  output logic move_o,
  output logic fault_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] mode_q;
  logic [15:0] ctrl_q;
  logic [31:0] offset_q;
  logic [7:0] method_q;
  logic [31:0] sw_speed_q;
  logic [31:0] idx_speed_q;
  logic [31:0] accel_q;
  logic [31:0] tol_q;
  logic [15:0] blk_cur_q;
  logic [15:0] blk_dur_q;
  logic [1:0] drive_q;
  logic [31:0] pos_q;
  logic [2:0] code_q;
  ahs_pkg::ahs_state_t state_q;
  logic err_q;
  logic [31:0] over_q;
  logic [16:0] ms_cnt_q;
  logic [15:0] ms_q;
  logic dir_q;
  logic phase_edge_q;

  // Input synchronisers (first stage read only by second)
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] sync3_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
    end else begin
      sync1_q <= {standstill_i, index_i, home_sw_i, pos_limit_i, neg_limit_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  logic nlim, plim, home, still, idx_rise, home_edge;
  assign nlim = sync2_q[0];
  assign plim = sync2_q[1];
  assign home = sync2_q[2];
  assign still = sync2_q[4];
  assign idx_rise = sync2_q[3] & ~sync3_q[3];
  assign home_edge = sync2_q[2] ^ sync3_q[2];

  // ****************************************************************
  // Method decoder
  // ****************************************************************
  logic signed [7:0] meth_s;
  logic [7:0] mabs;
  logic blk, legal, use_idx, use_limit, limit_pos, idx_only, present;
  logic left_edge_ref;
  assign meth_s = method_q;
  assign blk = meth_s < 0;
  assign mabs = blk ? 8'(-meth_s) : method_q;
  logic [7:0] base;
  // Non-index methods 17-30 map to the same profile as 1-14
  assign base = (mabs >= 8'(ahs_pkg::M_NOIDX_FIRST) && mabs <= 8'(ahs_pkg::M_NOIDX_LAST)) ? mabs - 8'd16 : mabs;
  assign use_idx = (mabs <= 8'(ahs_pkg::M_IDX_LAST)) || idx_only;
  assign idx_only = (mabs == 8'(ahs_pkg::M_IDX_ONLY_LO)) || (mabs == 8'(ahs_pkg::M_IDX_ONLY_HI));
  assign present = mabs == 8'(ahs_pkg::M_PRESENT);
  assign use_limit = (base == 8'd1) || (base == 8'd2);
  assign limit_pos = base == 8'd2;
  // Left edge is 3,4; right is 5,6
  assign left_edge_ref = (base == 8'd3) || (base == 8'd4);
  always_comb begin
    if (blk) begin
      legal = drive_q[ahs_pkg::DRV_CLOSED_LOOP_BIT] &&
              ((base == 8'd1) || (base == 8'd2) || (base >= 8'd7 && base <= 8'd14));
    end else begin
      legal = (base >= 8'd1 && base <= 8'd14) || idx_only || present;
    end
  end
  // 7-10 positive side first, 11-14 negative
  logic start_neg;
  always_comb begin
    if (use_limit) begin
      start_neg = ~limit_pos;
    end else if (base >= 8'd7 && base <= 8'd14) begin
      start_neg = base >= 8'd11;
    end else if (idx_only) begin
      start_neg = mabs == 8'(ahs_pkg::M_IDX_ONLY_LO);
    end else begin
      start_neg = base[0];
    end
  end

  // ****************************************************************
  // Control
  // ****************************************************************
  logic start, run_ok, limit_hit, ref_hit;
  // Bit 4 starts and holds the run, only while the mode register holds HOMING_MODE (6)
  assign start = (mode_q == ahs_pkg::HOMING_MODE) && ctrl_q[ahs_pkg::CTRL_START_BIT];
  assign run_ok = present || drive_q[ahs_pkg::DRV_OP_ENABLED_BIT];
  assign limit_hit = dir_q ? nlim : plim;
  assign ref_hit = blk ? (motor_current_i > blk_cur_q) : (use_limit ? limit_hit : home_edge);

  // Millisecond tick for push period
  logic ms_tick;
  assign ms_tick = ms_cnt_q == 17'(ahs_pkg::CYCLES_PER_MS - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ahs_pkg::AHS_PUSH) begin
      ms_cnt_q <= 17'h0_0000;
      ms_q <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt_q <= 17'h0_0000;
      ms_q <= ms_q + 16'h0001;
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'h0_0001;
    end
  end

  // Homing state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ahs_pkg::AHS_IDLE;
      dir_q <= 1'b0;
      err_q <= 1'b0;
      phase_edge_q <= 1'b0;
    end else if (!start) begin
      state_q <= ahs_pkg::AHS_IDLE;
      err_q <= 1'b0;
    end else if (over_q > tol_q && state_q != ahs_pkg::AHS_IDLE && state_q != ahs_pkg::AHS_DONE) begin
      state_q <= ahs_pkg::AHS_FAULT;
      err_q <= 1'b1;
    end else begin
      case (state_q)
        ahs_pkg::AHS_IDLE: begin
          if (!legal || !run_ok) begin
            state_q <= ahs_pkg::AHS_STOPPING;
            err_q <= 1'b1;
          end else if (present) begin
            state_q <= ahs_pkg::AHS_DONE;
          end else begin
            dir_q <= start_neg;
            phase_edge_q <= 1'b0;
            state_q <= idx_only ? ahs_pkg::AHS_SEARCH_IDX : ahs_pkg::AHS_SEARCH_SW;
          end
        end
        ahs_pkg::AHS_SEARCH_SW: begin
          if (ref_hit) begin
            if (blk) begin
              state_q <= ahs_pkg::AHS_PUSH;
            end else if (!use_limit && left_edge_ref == home && !phase_edge_q) begin
              phase_edge_q <= 1'b1;
            end else begin
              dir_q <= ~dir_q;
              state_q <= use_idx ? ahs_pkg::AHS_SEARCH_IDX : ahs_pkg::AHS_STOPPING;
            end
          end else if (!blk && !use_limit && limit_hit) begin
            dir_q <= ~dir_q;
          end
        end
        ahs_pkg::AHS_PUSH: begin
          if (ms_q >= blk_dur_q) begin
            dir_q <= ~dir_q;
            state_q <= use_idx ? ahs_pkg::AHS_SEARCH_IDX : ahs_pkg::AHS_STOPPING;
          end
        end
        ahs_pkg::AHS_SEARCH_IDX: begin
          if (idx_rise) begin
            state_q <= ahs_pkg::AHS_STOPPING;
          end
        end
        ahs_pkg::AHS_STOPPING: begin
          if (still) begin
            state_q <= err_q ? ahs_pkg::AHS_FAULT : ahs_pkg::AHS_DONE;
          end
        end
        ahs_pkg::AHS_DONE: state_q <= ahs_pkg::AHS_DONE;
        ahs_pkg::AHS_FAULT: err_q <= 1'b1;
        default: state_q <= ahs_pkg::AHS_IDLE;
      endcase
    end
  end

  // Overtravel after a limit is reached
  always_ff @(posedge clk_i) begin
    if (rst_i || !(plim || nlim)) begin
      over_q <= 32'h0000_0000;
    end else if (pos_step_i) begin
      over_q <= over_q + (pos_delta_i[31] ? -pos_delta_i : pos_delta_i);
    end
  end

  // Load offset on success, else track travel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 32'h0000_0000;
    end else if (start && ((state_q == ahs_pkg::AHS_STOPPING && still && !err_q) ||
                           (state_q == ahs_pkg::AHS_IDLE && present && legal))) begin
      pos_q <= offset_q;
    end else if (pos_step_i) begin
      pos_q <= pos_q + pos_delta_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_q <= ahs_pkg::ST_IDLE;
    end else begin
      case (state_q)
        ahs_pkg::AHS_IDLE: code_q <= ahs_pkg::ST_IDLE;
        ahs_pkg::AHS_STOPPING: code_q <= err_q ? ahs_pkg::ST_ERR_MOVING : ahs_pkg::ST_CONFIRMED;
        ahs_pkg::AHS_DONE: code_q <= start ? ahs_pkg::ST_DONE : ahs_pkg::ST_IDLE;
        ahs_pkg::AHS_FAULT: code_q <= still ? ahs_pkg::ST_ERR_STILL : ahs_pkg::ST_ERR_MOVING;
        default: code_q <= ahs_pkg::ST_RUNNING;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_cmd_o <= 32'h0000_0000;
      accel_cmd_o <= 32'h0000_0000;
      dir_neg_o <= 1'b0;
      move_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      speed_cmd_o <= (state_q == ahs_pkg::AHS_SEARCH_IDX) ? idx_speed_q : sw_speed_q;
      accel_cmd_o <= accel_q;
      dir_neg_o <= dir_q;
      move_o <= start && (state_q == ahs_pkg::AHS_SEARCH_SW || state_q == ahs_pkg::AHS_SEARCH_IDX ||
                          state_q == ahs_pkg::AHS_PUSH);
      fault_o <= state_q == ahs_pkg::AHS_FAULT;
    end
  end

  // ****************************************************************
  // Wishbone slave: one-cycle ack
  // ****************************************************************
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Register writes need all four byte lanes; narrow registers keep the low bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 8'h00;
      ctrl_q <= 16'h0000;
      offset_q <= 32'h0000_0000;
      method_q <= 8'h00;
      sw_speed_q <= 32'h0000_0000;
      idx_speed_q <= 32'h0000_0000;
      accel_q <= 32'h0000_0000;
      tol_q <= 32'h0000_0000;
      blk_cur_q <= 16'h0000;
      blk_dur_q <= 16'h0000;
      drive_q <= 2'h0;
    end else if (wr && wb_sel_i == 4'hf) begin
      case (wb_adr_i)
        ahs_pkg::MODE_SEL_ADDR: mode_q <= wb_dat_i[7:0];
        ahs_pkg::CTRL_ADDR: ctrl_q <= wb_dat_i[15:0];
        ahs_pkg::OFFSET_ADDR: offset_q <= wb_dat_i;
        ahs_pkg::METHOD_ADDR: method_q <= wb_dat_i[7:0];
        ahs_pkg::SW_SPEED_ADDR: sw_speed_q <= wb_dat_i;
        ahs_pkg::IDX_SPEED_ADDR: idx_speed_q <= wb_dat_i;
        ahs_pkg::ACCEL_ADDR: accel_q <= wb_dat_i;
        ahs_pkg::TOL_ADDR: tol_q <= wb_dat_i;
        ahs_pkg::BLK_CUR_ADDR: blk_cur_q <= wb_dat_i[15:0];
        ahs_pkg::BLK_DUR_ADDR: blk_dur_q <= wb_dat_i[15:0];
        ahs_pkg::DRIVE_ADDR: drive_q <= wb_dat_i[1:0];
        default: drive_q <= drive_q;
      endcase
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        ahs_pkg::MODE_SEL_ADDR: wb_dat_o <= {24'h00_0000, mode_q};
        ahs_pkg::CTRL_ADDR: wb_dat_o <= {16'h0000, ctrl_q};
        ahs_pkg::STATUS_ADDR: begin
          wb_dat_o <= 32'h0000_0000;
          wb_dat_o[ahs_pkg::ST_B13] <= code_q[2];
          wb_dat_o[ahs_pkg::ST_B12] <= code_q[1];
          wb_dat_o[ahs_pkg::ST_B10] <= code_q[0];
        end
        ahs_pkg::OFFSET_ADDR: wb_dat_o <= offset_q;
        ahs_pkg::METHOD_ADDR: wb_dat_o <= {24'h00_0000, method_q};
        ahs_pkg::SW_SPEED_ADDR: wb_dat_o <= sw_speed_q;
        ahs_pkg::IDX_SPEED_ADDR: wb_dat_o <= idx_speed_q;
        ahs_pkg::ACCEL_ADDR: wb_dat_o <= accel_q;
        ahs_pkg::TOL_ADDR: wb_dat_o <= tol_q;
        ahs_pkg::BLK_CUR_ADDR: wb_dat_o <= {16'h0000, blk_cur_q};
        ahs_pkg::BLK_DUR_ADDR: wb_dat_o <= {16'h0000, blk_dur_q};
        ahs_pkg::POS_ADDR: wb_dat_o <= pos_q;
        ahs_pkg::DRIVE_ADDR: wb_dat_o <= {30'h0000_0000, drive_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : ahs_homing

// [hdl/ahs_pkg.sv]
package ahs_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] MODE_SEL_ADDR = 8'h00;
  localparam logic [7:0] CTRL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] OFFSET_ADDR = 8'h0c;
  localparam logic [7:0] METHOD_ADDR = 8'h10;
  localparam logic [7:0] SW_SPEED_ADDR = 8'h14;
  localparam logic [7:0] IDX_SPEED_ADDR = 8'h18;
  localparam logic [7:0] ACCEL_ADDR = 8'h1c;
  localparam logic [7:0] TOL_ADDR = 8'h20;
  localparam logic [7:0] BLK_CUR_ADDR = 8'h24;
  localparam logic [7:0] BLK_DUR_ADDR = 8'h28;
  localparam logic [7:0] POS_ADDR = 8'h2c;
  localparam logic [7:0] DRIVE_ADDR = 8'h30;

  // ****************************************************************
  // Fields and values
  // ****************************************************************
  localparam logic [7:0] HOMING_MODE = 8'h06;
  localparam int CTRL_START_BIT = 4;
  localparam int ST_B10 = 10;
  localparam int ST_B12 = 12;
  localparam int ST_B13 = 13;
  localparam int DRV_CLOSED_LOOP_BIT = 0;
  localparam int DRV_OP_ENABLED_BIT = 1;

  // Status codes on bits 13,12,10
  localparam logic [2:0] ST_RUNNING = 3'h0;
  localparam logic [2:0] ST_IDLE = 3'h1;
  localparam logic [2:0] ST_CONFIRMED = 3'h2;
  localparam logic [2:0] ST_DONE = 3'h3;
  localparam logic [2:0] ST_ERR_MOVING = 3'h4;
  localparam logic [2:0] ST_ERR_STILL = 3'h5;

  // Method numbers used in the decoder
  localparam int M_IDX_LAST = 14;
  localparam int M_NOIDX_FIRST = 17;
  localparam int M_NOIDX_LAST = 30;
  localparam int M_IDX_ONLY_LO = 33;
  localparam int M_IDX_ONLY_HI = 34;
  localparam int M_PRESENT = 35;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  typedef enum logic [2:0] {
    AHS_IDLE = 3'b000,
    AHS_SEARCH_SW = 3'b001,
    AHS_SEARCH_IDX = 3'b010,
    AHS_PUSH = 3'b011,
    AHS_STOPPING = 3'b100,
    AHS_DONE = 3'b101,
    AHS_FAULT = 3'b110
  } ahs_state_t;

endpackage : ahs_pkg

// [testbench/ahs_props.sv]
`timescale 1ns/1ns
module ahs_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [31:0] speed_cmd_o,
  input wire logic [31:0] accel_cmd_o,
  input wire logic dir_neg_o,
  input wire logic move_o,
  input wire logic fault_o
);
  // ****************************************************************
  // Port checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd_ack;
  // Read answer seen on the bus
  assign rd_ack = wb_ack_o && !wb_we_i;
  // Ack is one pulse, one edge after the request
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  // Outputs quiet on leaving reset
  reset_quiet_a: assert property ($fell(rst_i) |-> !move_o && !fault_o && !dir_neg_o && speed_cmd_o == 32'h0
    && accel_cmd_o == 32'h0) else $error("output active after reset");
  status_code_a: assert property (rd_ack && wb_adr_i == ahs_pkg::STATUS_ADDR |->
    {wb_dat_o[13], wb_dat_o[12], wb_dat_o[10]} <= 3'h5) else $error("status code out of range");
  // Reads above the DRIVE_ADDR word return zero
  unmapped_zero_a: assert property (rd_ack && wb_adr_i > ahs_pkg::DRIVE_ADDR |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  mode_narrow_a: assert property (rd_ack && wb_adr_i == ahs_pkg::MODE_SEL_ADDR |->
    wb_dat_o[31:8] == 24'h0) else $error("mode upper bits set");
  fault_halts_a: assert property (fault_o |=> !move_o) else $error("motor runs in fault");
  cover property (rd_ack && wb_adr_i == ahs_pkg::POS_ADDR);
  cover property ($rose(move_o));
  cover property ($rose(fault_o));
endmodule : ahs_props
bind ahs_homing ahs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .speed_cmd_o(speed_cmd_o),
  .accel_cmd_o(accel_cmd_o), .dir_neg_o(dir_neg_o), .move_o(move_o), .fault_o(fault_o));

// [testbench/ahs_plant.sv]
`timescale 1ns/1ns
module ahs_plant #(parameter int STEP = 4) (
  input wire logic clk_i,
  input wire logic move_i,
  input wire logic dir_neg_i,
  input wire logic block_i,
  output logic neg_limit_o,
  output logic pos_limit_o,
  output logic home_sw_o,
  output logic index_o = 1'b0,
  output logic [15:0] current_o,
  output logic standstill_o,
  output logic [31:0] delta_o,
  output logic step_o = 1'b0
);
  // ****************************************************************
  // Axis with limit switches at +-80, home switch at 0 and hard stops at +-90
  // ****************************************************************
  int pos_q = 40;
  int div_q = 0;
  int brk_q = 0;
  int still_q = 0;
  int nxt;
  logic run;
  // Switches, encoder and current seen by the drive
  assign run = move_i || brk_q > 0;
  assign nxt = dir_neg_i ? pos_q - 1 : pos_q + 1;
  assign neg_limit_o = !block_i && pos_q <= -80;
  assign pos_limit_o = !block_i && pos_q >= 80;
  assign home_sw_o = pos_q >= 0;
  assign current_o = (move_i && (nxt > 90 || nxt < -90)) ? 16'hffff : 16'h0010; // Pushing a stop
  assign standstill_o = still_q >= 4;
  assign delta_o = dir_neg_i ? 32'hffff_ffff : 32'h0000_0001;
  // One unit each STEP cycles; coasts three units after move drops
  always_ff @(posedge clk_i) begin
    div_q <= (div_q == STEP - 1) ? 0 : div_q + 1;
    still_q <= run ? 0 : still_q + 1;
    step_o <= 1'b0;
    index_o <= 1'b0;
    if (move_i) brk_q <= 3;
    else if (brk_q > 0 && div_q == 0) brk_q <= brk_q - 1;
    if (run && div_q == 0 && nxt <= 90 && nxt >= -90) begin
      pos_q <= nxt;
      step_o <= 1'b1;
      index_o <= nxt[3:0] == 4'h0;
    end
  end
endmodule : ahs_plant

// [testbench/ahs_homing_bench.sv]
`timescale 1ns/1ns
module ahs_homing_bench;
  // ****************************************************************
  // Clock, design and axis model
  // ****************************************************************
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, nl, pl, hs, ix, ss, ps, blk, move_o, fault_o, dir_neg_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [15:0] cur;
  logic [31:0] wb_dat_i, wb_dat_o, pd, speed_cmd_o, accel_cmd_o, rd, seed, off, sws, ixs, acc;
  logic [63:0] expq[$];
  logic [7:0] regs[5] = '{ahs_pkg::OFFSET_ADDR, ahs_pkg::SW_SPEED_ADDR, ahs_pkg::IDX_SPEED_ADDR,
    ahs_pkg::ACCEL_ADDR, ahs_pkg::TOL_ADDR};
  logic [7:0] meth[14] = '{1, 2, 17, 18, 33, 34, 3, 5, 7, 11, 19, 21, 23, 27};
  logic [7:0] bad[4] = '{8'h0f, 8'h10, 8'hfd, 8'hf1};
  int err_total, n_checks, n;
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ahs_homing DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .neg_limit_i(nl), .pos_limit_i(pl), .home_sw_i(hs), .index_i(ix), .motor_current_i(cur), .standstill_i(ss),
    .pos_delta_i(pd), .pos_step_i(ps), .speed_cmd_o(speed_cmd_o), .accel_cmd_o(accel_cmd_o),
    .dir_neg_o(dir_neg_o), .move_o(move_o), .fault_o(fault_o));
  ahs_plant PLANT (.clk_i(clk_i), .move_i(move_o), .dir_neg_i(dir_neg_o), .block_i(blk), .neg_limit_o(nl),
    .pos_limit_o(pl), .home_sw_o(hs), .index_o(ix), .current_o(cur), .standstill_o(ss), .delta_o(pd), .step_o(ps));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] stw(input logic [2:0] c);
    return {18'h0, c[2], c[1], 1'b0, c[0], 10'h0};
  endfunction : stw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, s};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k == 20) chk(32'h0, 32'h1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr
  // Notes the expected masked word, then reads
  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back({e & m, m});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rdx
  // Polls status until code c shows, then checks it
  task automatic waitc(input logic [2:0] c);
    int k;
    k = 0;
    do begin
      rdx(ahs_pkg::STATUS_ADDR, 32'h0, 32'h0);
      k++;
    end while ({rd[13], rd[12], rd[10]} !== c && k < 2000);
    rdx(ahs_pkg::STATUS_ADDR, stw(c), 32'h0000_3400);
  endtask : waitc
  task automatic home(input logic [7:0] md, input logic [7:0] m, input logic [1:0] drv);
    wr(ahs_pkg::MODE_SEL_ADDR, {24'h0, md});
    wr(ahs_pkg::DRIVE_ADDR, {30'h0, drv});
    wr(ahs_pkg::METHOD_ADDR, {24'h0, m});
    wr(ahs_pkg::CTRL_ADDR, 32'h0000_0010);
  endtask : home
  task automatic abort();
    wr(ahs_pkg::CTRL_ADDR, 32'h0);
    waitc(ahs_pkg::ST_IDLE);
  endtask : abort
  task automatic waitsig(input logic f);
    n = 0;
    while (f ? fault_o !== 1'b1 : move_o !== 1'b1) begin
      @(posedge clk_i);
      if (++n > 3000) break;
    end
    repeat (2) @(posedge clk_i);
  endtask : waitsig
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Pops the oldest note for each read answer; compares only when its mask is nonzero
  always @(posedge clk_i) begin
    logic [63:0] e;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[31:0] !== 32'h0) chk(wb_dat_o & e[31:0], e[63:32]);
    end
  end
  initial begin
    #(8 * 95000);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    seed = 32'h0000_27c7;
    {wb_cyc_i, wb_stb_i, wb_we_i, blk, rst_i, wb_adr_i, wb_dat_i, wb_sel_i} = {5'h01, 44'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    waitc(ahs_pkg::ST_IDLE);
    rdx(ahs_pkg::POS_ADDR, 32'h0, 32'hffff_ffff);
    rdx(8'h40, 32'h0, 32'hffff_ffff);
    foreach (regs[i]) begin
      off = rnd();
      wr(regs[i], off);
      rdx(regs[i], off, 32'h0000_ffff);
    end
    bus(1'b1, ahs_pkg::TOL_ADDR, ~off, 4'h3);
    rdx(ahs_pkg::TOL_ADDR, off, 32'h0000_ffff);
    wr(ahs_pkg::POS_ADDR, rnd());
    rdx(ahs_pkg::POS_ADDR, 32'h0, 32'hffff_ffff);
    $display("test registers done");
    sws = (rnd() & 32'h0000_0fff) | 32'h0000_0100;
    ixs = (rnd() & 32'h0000_0fff) | 32'h0000_0100;
    acc = (rnd() & 32'h0000_0fff) | 32'h0000_0100;
    off = rnd();
    wr(ahs_pkg::SW_SPEED_ADDR, sws);
    wr(ahs_pkg::IDX_SPEED_ADDR, ixs);
    wr(ahs_pkg::ACCEL_ADDR, acc);
    wr(ahs_pkg::OFFSET_ADDR, off);
    wr(ahs_pkg::TOL_ADDR, 32'h0000_1000);
    wr(ahs_pkg::BLK_CUR_ADDR, 32'h0000_0100);
    wr(ahs_pkg::BLK_DUR_ADDR, 32'h0);
    home(8'h03, 8'd35, 2'h3);
    repeat (20) @(posedge clk_i);
    chk({31'h0, move_o}, 32'h0);
    waitc(ahs_pkg::ST_IDLE);
    wr(ahs_pkg::CTRL_ADDR, 32'h0);
    home(8'h06, 8'd35, 2'h0);
    waitc(ahs_pkg::ST_DONE);
    rdx(ahs_pkg::POS_ADDR, off, 32'hffff_ffff);
    abort();
    home(8'h06, 8'd17, 2'h3);
    waitsig(1'b0);
    waitc(ahs_pkg::ST_RUNNING);
    abort();
    chk({31'h0, move_o}, 32'h0);
    $display("test mode and abort done");
    foreach (meth[i]) begin
      home(8'h06, meth[i], 2'h3);
      waitsig(1'b0);
      chk(speed_cmd_o, meth[i] > 8'd32 ? ixs : sws);
      chk(accel_cmd_o, acc);
      if (i < 6) chk({31'h0, dir_neg_o}, {31'h0, meth[i][0]});
      waitc(ahs_pkg::ST_DONE);
      rdx(ahs_pkg::POS_ADDR, off, 32'hffff_ffff);
      abort();
    end
    $display("test methods done");
    blk <= 1'b1;
    home(8'h06, 8'hef, 2'h2);
    waitc(ahs_pkg::ST_ERR_STILL);
    abort();
    home(8'h06, 8'hef, 2'h3);
    waitc(ahs_pkg::ST_DONE);
    abort();
    home(8'h06, 8'hfe, 2'h3);
    waitc(ahs_pkg::ST_DONE);
    rdx(ahs_pkg::POS_ADDR, off, 32'hffff_ffff);
    abort();
    blk <= 1'b0;
    foreach (bad[i]) begin
      home(8'h06, bad[i], 2'h3);
      waitc(ahs_pkg::ST_ERR_STILL);
      abort();
    end
    $display("test block and illegal done");
    wr(ahs_pkg::TOL_ADDR, 32'h0);
    home(8'h06, 8'd18, 2'h3);
    waitsig(1'b1);
    chk({31'h0, fault_o}, 32'h1);
    chk({31'h0, move_o}, 32'h0);
    rdx(ahs_pkg::STATUS_ADDR, stw(ahs_pkg::ST_ERR_MOVING), 32'h0000_3400);
    waitc(ahs_pkg::ST_ERR_STILL);
    abort();
    $display("test overtravel done");
    stop_test();
  end
endmodule : ahs_homing_bench
